// ==== satx_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides, parameterised in width and depth.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module satx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : satx_fifo
`default_nettype wire

// ==== satx_framer.sv ====
// Transmit frame control: opening flag, CRC preset and accumulate, underrun close.
// Assumes an AHB-Lite master on one side and a bit-clock enable from the line side.
// Behaviour
// - Mark idle sends eight ones whole; no flag loads mid-character.
// - Without auto flag, data written during mark idle replaces the opening flag.
// - Auto flag works only with extended enable set and bit-oriented mode.
// - With auto flag, data written during mark idle gets an opening flag first.
// - Extended enable plus auto preset bit presets CRC to chosen value on each opening flag.
// - Extended enable plus auto preset bit clears underrun latch each new frame.
// - CRC accumulates only while the CRC enable bit is one.
// - CRC covers every data character between opening and closing flags, not the CRC characters.
// - Extended enable presets the CRC on every opening flag sent.
// - Underrun with latch set closes with flag; clear sends CRC or abort, flag.
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module satx_framer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bit_tick,
  output logic txd,
  output logic tx_buf_ready
);
  logic [7:0] extended_feature_control_reg;
  logic [7:0] auxiliary_tx_option_reg;
  logic [7:0] misc_tx_rx_control_reg;
  logic [7:0] tx_parameter_control_reg;
  logic tx_underrun_end_of_message_latch;
  logic ph_write_reg;
  logic ph_read_reg;
  logic [7:0] ph_addr_reg;
  logic [31:0] hrdata_next;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  satx_pkg::satx_state_t state_reg;
  satx_pkg::satx_char_t shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] ones_cnt_reg;
  logic [15:0] crc_reg;
  logic [15:0] crc_hold_reg;
  logic txd_reg;
  logic char_end;
  logic load_data;
  logic load_flag;
  logic cur_bit;
  logic stuff_now;
  logic ext_en;
  logic auto_flag;
  logic auto_preset;
  logic mark_idle;
  logic txen;
  logic crc_en;
  logic host_crc_reset;
  logic host_eom_reset;
  logic [15:0] crc_preset_val;
  logic [15:0] crc_step;
  logic frame_open_reg;
  logic need_flag;
  logic open_flag_now;
  logic underrun;
  logic cmd_write;

  assign ext_en = extended_feature_control_reg[satx_pkg::EXT_EN_BIT];
  assign auto_flag = ext_en && misc_tx_rx_control_reg[satx_pkg::MISC_SDLC_BIT]
    && auxiliary_tx_option_reg[satx_pkg::AUX_FLAG_BIT];
  assign auto_preset = ext_en && auxiliary_tx_option_reg[satx_pkg::AUX_PRESET_BIT];
  assign mark_idle = misc_tx_rx_control_reg[satx_pkg::MISC_MARK_BIT];
  assign txen = tx_parameter_control_reg[satx_pkg::TXP_TXEN_BIT];
  assign crc_en = tx_parameter_control_reg[satx_pkg::TXP_CRC_BIT];
  assign crc_preset_val = misc_tx_rx_control_reg[satx_pkg::MISC_PRESET_BIT] ?
    satx_pkg::CRC_ONES : satx_pkg::CRC_ZERO;

  // Bus slave: single-cycle answer, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write_reg <= 1'b0;
      ph_read_reg <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else if (hready) begin
      ph_write_reg <= hsel && htrans[1] && hwrite;
      ph_read_reg <= hsel && htrans[1] && !hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end
  assign cmd_write = ph_write_reg && (ph_addr_reg == satx_pkg::ADDR_CMD);
  assign host_crc_reset = cmd_write && (hwdata[7:0] == satx_pkg::CMD_RESET_CRC);
  assign host_eom_reset = cmd_write && (hwdata[7:0] == satx_pkg::CMD_RESET_EOM);
  assign fifo_in_valid = ph_write_reg && (ph_addr_reg == satx_pkg::ADDR_TXBUF);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      extended_feature_control_reg <= 8'h00;
      auxiliary_tx_option_reg <= 8'h00;
      misc_tx_rx_control_reg <= 8'h00;
      tx_parameter_control_reg <= 8'h00;
    end else if (ph_write_reg) begin
      case (ph_addr_reg)
        satx_pkg::ADDR_EXT: extended_feature_control_reg <= hwdata[7:0];
        satx_pkg::ADDR_AUX: auxiliary_tx_option_reg <= hwdata[7:0];
        satx_pkg::ADDR_MISC: misc_tx_rx_control_reg <= hwdata[7:0];
        satx_pkg::ADDR_TXP: tx_parameter_control_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    hrdata_next = 32'h0000_0000;
    case (ph_addr_reg)
      satx_pkg::ADDR_EXT: hrdata_next[7:0] = extended_feature_control_reg;
      satx_pkg::ADDR_AUX: hrdata_next[7:0] = auxiliary_tx_option_reg;
      satx_pkg::ADDR_MISC: hrdata_next[7:0] = misc_tx_rx_control_reg;
      satx_pkg::ADDR_TXP: hrdata_next[7:0] = tx_parameter_control_reg;
      satx_pkg::ADDR_STAT: hrdata_next[7:0] = {1'b0, tx_underrun_end_of_message_latch,
        frame_open_reg, state_reg == satx_pkg::ST_IDLE, 2'b00, fifo_out_valid, tx_buf_ready};
      default: hrdata_next = 32'h0000_0000;
    endcase
  end
  assign hrdata = ph_read_reg ? hrdata_next : 32'h0000_0000;

  satx_fifo #(
    .WIDTH(satx_pkg::FIFO_WIDTH),
    .DEPTH(satx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(fifo_in_valid),
    .in_ready(tx_buf_ready),
    .in_data(hwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Serializer: character boundary after eight bits, stuffed zeros add a bit.
  assign cur_bit = shift_reg.data[0];
  assign stuff_now = shift_reg.stuff && (ones_cnt_reg == 3'd5);
  assign char_end = bit_tick && !stuff_now && (bit_cnt_reg == satx_pkg::BIT_LAST);
  // Without auto flag, a mark idle frame opens with data directly.
  assign need_flag = !frame_open_reg && (auto_flag || !mark_idle);
  assign load_data = char_end && txen && fifo_out_valid
    && (state_reg == satx_pkg::ST_IDLE || state_reg == satx_pkg::ST_DATA)
    && !(state_reg == satx_pkg::ST_IDLE && need_flag);
  assign open_flag_now = char_end && txen && fifo_out_valid
    && state_reg == satx_pkg::ST_IDLE && need_flag;
  assign load_flag = open_flag_now;
  assign fifo_out_ready = load_data;
  assign underrun = char_end && state_reg == satx_pkg::ST_DATA && !fifo_out_valid;
  assign txd = txd_reg;

  always_comb begin
    crc_step = crc_reg;
    if (shift_reg.is_crc && crc_en && !stuff_now) begin
      crc_step = {crc_reg[14:0], 1'b0} ^ ((crc_reg[15] ^ cur_bit) ? satx_pkg::CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= satx_pkg::ST_IDLE;
      frame_open_reg <= 1'b0;
    end else if (char_end) begin
      case (state_reg)
        satx_pkg::ST_IDLE: begin
          if (load_flag || load_data) begin
            state_reg <= satx_pkg::ST_DATA;
            frame_open_reg <= 1'b1;
          end
        end
        satx_pkg::ST_DATA: begin
          if (underrun) begin
            if (tx_underrun_end_of_message_latch) begin
              state_reg <= satx_pkg::ST_CLOSE;
            end else if (misc_tx_rx_control_reg[satx_pkg::MISC_ABORT_BIT]) begin
              state_reg <= satx_pkg::ST_ABORT;
            end else begin
              state_reg <= satx_pkg::ST_CRC1;
            end
          end
        end
        satx_pkg::ST_CRC1: state_reg <= satx_pkg::ST_CRC2;
        satx_pkg::ST_CRC2: state_reg <= satx_pkg::ST_CLOSE;
        satx_pkg::ST_ABORT: state_reg <= satx_pkg::ST_CLOSE;
        satx_pkg::ST_CLOSE: begin
          state_reg <= satx_pkg::ST_IDLE;
          frame_open_reg <= 1'b0;
        end
        default: state_reg <= satx_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= '{data: satx_pkg::MARK_CHAR, stuff: 1'b0, is_crc: 1'b0};
      bit_cnt_reg <= 3'd0;
      ones_cnt_reg <= 3'd0;
      txd_reg <= 1'b1;
    end else if (bit_tick) begin
      if (stuff_now) begin
        txd_reg <= 1'b0;
        ones_cnt_reg <= 3'd0;
      end else begin
        txd_reg <= cur_bit;
        ones_cnt_reg <= cur_bit ? ones_cnt_reg + 3'd1 : 3'd0;
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        shift_reg.data <= {1'b1, shift_reg.data[7:1]};
      end
      if (char_end) begin
        if (load_flag) begin
          shift_reg <= '{data: satx_pkg::FLAG_CHAR, stuff: 1'b0, is_crc: 1'b0};
        end else if (load_data) begin
          shift_reg <= '{data: fifo_out_data, stuff: 1'b1, is_crc: 1'b1};
        end else if (state_reg == satx_pkg::ST_DATA && underrun
          && !tx_underrun_end_of_message_latch
          && !misc_tx_rx_control_reg[satx_pkg::MISC_ABORT_BIT]) begin
          shift_reg <= '{data: ~crc_step[15:8], stuff: 1'b1, is_crc: 1'b0};
        end else if (state_reg == satx_pkg::ST_CRC1) begin
          shift_reg <= '{data: ~crc_hold_reg[7:0], stuff: 1'b1, is_crc: 1'b0};
        end else if (state_reg == satx_pkg::ST_DATA && underrun
          && !tx_underrun_end_of_message_latch) begin
          shift_reg <= '{data: satx_pkg::ABORT_CHAR, stuff: 1'b0, is_crc: 1'b0};
        end else if (state_reg == satx_pkg::ST_DATA || state_reg == satx_pkg::ST_CRC2
          || state_reg == satx_pkg::ST_ABORT || !mark_idle) begin
          shift_reg <= '{data: satx_pkg::FLAG_CHAR, stuff: 1'b0, is_crc: 1'b0};
        end else begin
          shift_reg <= '{data: satx_pkg::MARK_CHAR, stuff: 1'b0, is_crc: 1'b0};
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_reg <= satx_pkg::CRC_ONES;
      crc_hold_reg <= satx_pkg::CRC_ONES;
    end else begin
      if (open_flag_now && ext_en) begin
        crc_reg <= auto_preset ? crc_preset_val : satx_pkg::CRC_ONES;
      end else if (host_crc_reset) begin
        crc_reg <= crc_preset_val;
      end else if (bit_tick) begin
        crc_reg <= crc_step;
      end
      if (underrun) begin
        crc_hold_reg <= crc_step;
      end
    end
  end

  // Latch set by underrun wins over a host or automatic clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_underrun_end_of_message_latch <= 1'b1;
    end else if (underrun) begin
      tx_underrun_end_of_message_latch <= 1'b1;
    end else if (host_eom_reset
      || (auto_preset && char_end && state_reg == satx_pkg::ST_IDLE
      && (load_flag || load_data))) begin
      tx_underrun_end_of_message_latch <= 1'b0;
    end
  end

  property p_flag_only_at_boundary;
    @(posedge hclk) disable iff (!hresetn)
      load_flag |-> char_end && bit_cnt_reg == satx_pkg::BIT_LAST;
  endproperty
  a_flag_only_at_boundary: assert property (p_flag_only_at_boundary)
    else $error("flag loaded mid character");
  property p_no_flag_mark;
    @(posedge hclk) disable iff (!hresetn)
      (open_flag_now && mark_idle) |-> auto_flag;
  endproperty
  a_no_flag_mark: assert property (p_no_flag_mark)
    else $error("opening flag sent in mark idle without auto flag");
  property p_auto_needs_ext;
    @(posedge hclk) disable iff (!hresetn)
      auto_flag |-> ext_en && misc_tx_rx_control_reg[satx_pkg::MISC_SDLC_BIT];
  endproperty
  a_auto_needs_ext: assert property (p_auto_needs_ext)
    else $error("auto flag active without extended enable");
  property p_auto_flag_sent;
    @(posedge hclk) disable iff (!hresetn)
      (char_end && txen && fifo_out_valid && state_reg == satx_pkg::ST_IDLE
      && !frame_open_reg && auto_flag) |=> shift_reg.data == satx_pkg::FLAG_CHAR;
  endproperty
  a_auto_flag_sent: assert property (p_auto_flag_sent)
    else $error("auto flag not loaded");
  property p_preset;
    @(posedge hclk) disable iff (!hresetn)
      (open_flag_now && auto_preset) |=> crc_reg == $past(crc_preset_val);
  endproperty
  a_preset: assert property (p_preset)
    else $error("crc not preset on opening flag");
  property p_eom_clear;
    @(posedge hclk) disable iff (!hresetn)
      (open_flag_now && auto_preset) |=> !tx_underrun_end_of_message_latch;
  endproperty
  a_eom_clear: assert property (p_eom_clear)
    else $error("underrun latch not cleared on new frame");
  property p_crc_hold;
    @(posedge hclk) disable iff (!hresetn)
      (bit_tick && !crc_en && !open_flag_now && !host_crc_reset) |=> $stable(crc_reg);
  endproperty
  a_crc_hold: assert property (p_crc_hold)
    else $error("crc changed while disabled");
  property p_underrun_close;
    @(posedge hclk) disable iff (!hresetn)
      (underrun && tx_underrun_end_of_message_latch) |=> state_reg == satx_pkg::ST_CLOSE;
  endproperty
  a_underrun_close: assert property (p_underrun_close)
    else $error("underrun with latch set did not close");
  c_auto_flag: cover property (@(posedge hclk) disable iff (!hresetn) open_flag_now && mark_idle);
  c_crc_path: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == satx_pkg::ST_CRC2);
  c_abort_path: cover property (@(posedge hclk) disable iff (!hresetn)
    state_reg == satx_pkg::ST_ABORT);
endmodule : satx_framer
`default_nettype wire

// ==== satx_framer_tb.sv ====
// Testbench of the transmit framer: bus master, scoreboard and remote station.
// Assumes a zero-wait slave whose hreadyout is the bus's hready.
`timescale 1ns/1ns
`default_nettype none
module satx_framer_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bit_tick, txd, tx_buf_ready;
  logic tick_on, rx_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tick_gap;
  logic [9:0] rx_item;
  logic [9:0] exp_q[$];
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  satx_framer satx_framer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bit_tick(bit_tick), .txd(txd),
    .tx_buf_ready(tx_buf_ready));
  satx_remote_station satx_remote_station_inst (.hclk(hclk), .hresetn(hresetn),
    .tick_on(tick_on), .tick_gap(tick_gap), .txd(txd), .bit_tick(bit_tick),
    .rx_valid(rx_valid), .rx_item(rx_item));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  // Every decoded byte, frame end or abort takes the oldest expectation.
  always @(posedge hclk) begin
    if (rx_valid === 1'b1 && exp_q.size() == 0) begin
      check({22'h0, rx_item}, 32'h0000_1000);
    end else if (rx_valid === 1'b1) begin
      check({22'h0, rx_item}, {22'h0, exp_q.pop_front()});
    end
  end
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask : rchk
  task wait_done;
    int i;
    i = 0;
    do begin
      bus(1'b0, satx_pkg::ADDR_STAT, 32'h0000_0000);
      i++;
    end while (i < 5000 && !(exp_q.size() == 0 && (rd & 32'h0000_0012) === 32'h0000_0010));
    repeat (24) @(posedge bit_tick);
  endtask : wait_done
  // Modes: 0 flag close, 1 CRC then flag, 2 abort, 3 no frame seen on the line.
  task automatic frame(input int n, input int mode, input logic [15:0] pre, input logic eom,
    input logic stall);
    logic [7:0] b[$];
    logic [15:0] c;
    int k;
    c = pre;
    k = (n > 16) ? 16 : n;
    for (int i = 0; i < n; i++) b.push_back(8'($urandom));
    for (int i = 0; i < k; i++) begin
      if (mode != 3 && !(mode == 2 && i == k - 1)) exp_q.push_back({2'h0, b[i]});
      for (int j = 0; j < 8; j++) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][j]) ? satx_pkg::CRC_POLY : 16'h0000);
      end
    end
    if (mode == 1) exp_q.push_back({2'h0, ~c[15:8]});
    if (mode == 1) exp_q.push_back({2'h0, ~c[7:0]});
    if (mode < 2) exp_q.push_back(10'h100);
    if (mode == 2) exp_q.push_back(10'h200);
    @(posedge hclk);
    tick_on <= !stall;
    for (int i = 0; i < n; i++) begin
      bus(1'b1, satx_pkg::ADDR_TXBUF, {24'h00_0000, b[i]});
      if (eom && i == 0) bus(1'b1, satx_pkg::ADDR_CMD, {24'h00_0000, satx_pkg::CMD_RESET_EOM});
    end
    if (stall) begin
      check({31'h0, tx_buf_ready}, 32'h0000_0000);
      rchk(satx_pkg::ADDR_STAT, 32'h0000_0052);
      tick_on <= 1'b1;
    end
    wait_done();
  endtask : frame
  function automatic int rnd();
    return 2 + int'($urandom % 15);
  endfunction : rnd
  initial begin
    {hresetn, hsel, hwrite, tick_on} = 4'h0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'b010;
    tick_gap = 4'h3;
    void'($urandom(32'ha7687177));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(satx_pkg::ADDR_STAT, 32'h0000_0051);
    rchk(8'h1C, 32'h0000_0000);
    bus(1'b1, satx_pkg::ADDR_EXT, 32'h0000_0001);
    bus(1'b1, satx_pkg::ADDR_TXP, 32'h0000_0009);
    bus(1'b1, satx_pkg::ADDR_MISC, 32'h0000_0010);
    bus(1'b1, satx_pkg::ADDR_AUX, 32'h0000_0002);
    rchk(satx_pkg::ADDR_AUX, 32'h0000_0002);
    frame(17, 1, satx_pkg::CRC_ZERO, 1'b0, 1'b1);
    bus(1'b1, satx_pkg::ADDR_AUX, 32'h0000_0000);
    bus(1'b1, satx_pkg::ADDR_CMD, {24'h00_0000, satx_pkg::CMD_RESET_CRC});
    frame(rnd(), 1, satx_pkg::CRC_ONES, 1'b1, 1'b0);
    bus(1'b1, satx_pkg::ADDR_MISC, 32'h0000_0018);
    repeat (24) @(posedge bit_tick);
    frame(rnd(), 3, satx_pkg::CRC_ZERO, 1'b0, 1'b0);
    bus(1'b1, satx_pkg::ADDR_MISC, 32'h0000_0010);
    frame(rnd(), 0, satx_pkg::CRC_ZERO, 1'b0, 1'b0);
    tick_gap <= 4'h9;
    bus(1'b1, satx_pkg::ADDR_MISC, 32'h0000_0014);
    frame(rnd(), 2, satx_pkg::CRC_ZERO, 1'b1, 1'b0);
    tick_gap <= 4'h3;
    bus(1'b1, satx_pkg::ADDR_EXT, 32'h0000_0000);
    bus(1'b1, satx_pkg::ADDR_MISC, 32'h0000_0018);
    bus(1'b1, satx_pkg::ADDR_AUX, 32'h0000_0001);
    repeat (24) @(posedge bit_tick);
    frame(rnd(), 3, satx_pkg::CRC_ZERO, 1'b0, 1'b0);
    bus(1'b1, satx_pkg::ADDR_EXT, 32'h0000_0001);
    frame(rnd(), 0, satx_pkg::CRC_ZERO, 1'b0, 1'b0);
    check(32'(exp_q.size()), 32'h0000_0000);
    give_verdict();
  end
endmodule : satx_framer_tb
`default_nettype wire

// ==== satx_pkg.sv ====
// Package for the bit-oriented transmit framer: register map, fields, codes and states.
// Assumes an AHB-Lite slave with 32-bit words; no other file defines these names.
package satx_pkg;
  localparam logic [7:0] ADDR_EXT = 8'h00;
  localparam logic [7:0] ADDR_AUX = 8'h04;
  localparam logic [7:0] ADDR_MISC = 8'h08;
  localparam logic [7:0] ADDR_TXP = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_TXBUF = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam int EXT_EN_BIT = 0;
  localparam int AUX_FLAG_BIT = 0;
  localparam int AUX_PRESET_BIT = 1;
  localparam int MISC_ABORT_BIT = 2;
  localparam int MISC_MARK_BIT = 3;
  localparam int MISC_SDLC_BIT = 4;
  localparam int MISC_PRESET_BIT = 7;
  localparam int TXP_CRC_BIT = 0;
  localparam int TXP_TXEN_BIT = 3;
  localparam logic [7:0] CMD_RESET_CRC = 8'h80;
  localparam logic [7:0] CMD_RESET_EOM = 8'hC0;
  localparam logic [7:0] FLAG_CHAR = 8'h7E;
  localparam logic [7:0] MARK_CHAR = 8'hFF;
  localparam logic [7:0] ABORT_CHAR = 8'h7F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_ONES = 16'hFFFF;
  localparam logic [15:0] CRC_ZERO = 16'h0000;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_DATA = 6'b00_0010,
    ST_CRC1 = 6'b00_0100,
    ST_CRC2 = 6'b00_1000,
    ST_ABORT = 6'b01_0000,
    ST_CLOSE = 6'b10_0000
  } satx_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic stuff;
    logic is_crc;
  } satx_char_t;
endpackage : satx_pkg

// ==== satx_remote_station.sv ====
// Remote station model: makes the bit clock enable, samples txd and decodes frames.
// Assumes txd moves one cycle after bit_tick and the tick gap is at least 2.
`timescale 1ns/1ns
`default_nettype none
module satx_remote_station (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick_on,
  input wire logic [3:0] tick_gap,
  input wire logic txd,
  output logic bit_tick,
  output logic rx_valid,
  output logic [9:0] rx_item
);
  logic [3:0] cnt_reg;
  logic [7:0] win_reg;
  logic [7:0] sh_reg;
  logic [3:0] vld_reg;
  logic [2:0] ones_reg;
  logic [2:0] nbit_reg;
  logic [4:0] nbyte_reg;
  logic in_frame_reg;
  logic [7:0] nwin;
  logic [7:0] nsh;
  // Data bits leave after a seven-bit delay, so a closing flag never swallows the last data bit.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cnt_reg, win_reg, sh_reg, vld_reg, ones_reg, nbit_reg, nbyte_reg} <= '0;
      {in_frame_reg, bit_tick, rx_valid, rx_item} <= '0;
    end else begin
      rx_valid <= 1'b0;
      bit_tick <= tick_on && (cnt_reg >= tick_gap);
      if (tick_on) begin
        cnt_reg <= (cnt_reg >= tick_gap) ? 4'h0 : cnt_reg + 4'h1;
      end
      if (bit_tick) begin
        nwin = {txd, win_reg[7:1]};
        win_reg <= nwin;
        if (nwin == satx_pkg::FLAG_CHAR) begin
          if (in_frame_reg && nbyte_reg != 5'h00 && nbit_reg == 3'h0) begin
            rx_valid <= 1'b1;
            rx_item <= 10'h100;
          end
          in_frame_reg <= 1'b1;
          {nbyte_reg, nbit_reg, vld_reg, ones_reg} <= '0;
        end else if (nwin[7:1] == 7'h7F) begin
          if (in_frame_reg && nbyte_reg != 5'h00) begin
            rx_valid <= 1'b1;
            rx_item <= 10'h200;
          end
          in_frame_reg <= 1'b0;
          {vld_reg, ones_reg} <= '0;
        end else if (vld_reg != 4'h7) begin
          vld_reg <= vld_reg + 4'h1;
        end else if (ones_reg == 3'h5 && !win_reg[1]) begin
          ones_reg <= 3'h0;
        end else begin
          ones_reg <= win_reg[1] ? ones_reg + 3'h1 : 3'h0;
          nsh = {win_reg[1], sh_reg[7:1]};
          sh_reg <= nsh;
          nbit_reg <= nbit_reg + 3'h1;
          if (nbit_reg == 3'h7 && in_frame_reg) begin
            rx_valid <= 1'b1;
            rx_item <= {2'h0, nsh};
            nbyte_reg <= nbyte_reg + 5'h01;
          end
        end
      end
    end
  end
endmodule : satx_remote_station
`default_nettype wire
